// ---- verilog/rpdr_top.sv ----
// Power-up control of the clock block: shared test/reset pin, power-up defaults of the
// control bits and the factory trim copy into the analog trim register.
// Assumes supply_good comes registered from the supply monitor and register accesses
// arrive as single-cycle strobes from the serial interface.
module rpdr_top #(
  parameter int unsigned HALF_PERIOD_CYCLES = rpdr_pkg::HALF_CYCLES,
  parameter int unsigned COPY_DELAY_CYCLES = rpdr_pkg::COPY_CYCLES,
  parameter logic [7:0] FACTORY_TRIM = rpdr_pkg::FACTORY_TRIM_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_good,
  input wire logic battery_retained,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ctrl_wr,
  input wire logic [rpdr_pkg::CTRL_W-1:0] ctrl_wdata,
  output logic [rpdr_pkg::CTRL_W-1:0] ctrl_bits,
  output logic [7:0] calibration_control,
  output logic [7:0] analog_trim,
  output logic trim_copy_busy,
  input wire logic test_or_reset_pin_in,
  output logic test_or_reset_pin_out,
  output logic test_or_reset_pin_oe
);
  import rpdr_pkg::*;

  logic rst_sync_n;
  logic sg_ok;
  logic sg_prev;
  logic sg_rise;
  logic sg_fall;
  logic freq_test_enable;
  logic wave;
  logic [WAVE_CNT_W-1:0] wave_cnt;
  logic [COPY_CNT_W-1:0] copy_cnt;
  logic trim_load;
  rpdr_trim_state_t trim_state;

  localparam logic [WAVE_CNT_W-1:0] WAVE_LAST = WAVE_CNT_W'(HALF_PERIOD_CYCLES - 1);
  localparam logic [COPY_CNT_W-1:0] COPY_LAST = COPY_CNT_W'(COPY_DELAY_CYCLES - 1);

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] cal,
                                          input logic [7:0] trim);
    logic [7:0] val;
    val = RDATA_NONE;
    if (addr == CAL_CTRL_ADDR) begin
      val = cal;
    end else if (addr == TRIM_ADDR) begin
      val = trim;
    end
    return val;
  endfunction

  rpdr_sync u_rst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(rst_sync_n)
  );

  // Supply good crosses into this domain before anything looks at it.
  rpdr_sync u_sg_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(supply_good),
    .q(sg_ok)
  );

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sg_prev <= 1'b0;
    end else begin
      sg_prev <= sg_ok;
    end
  end

  // The first good cycle after reset also counts as a power-up.
  assign sg_rise = sg_ok && !sg_prev;
  assign sg_fall = !sg_ok && sg_prev;
  assign freq_test_enable = calibration_control[FT_POS];
  assign trim_load = ctrl_bits[TRIM_LOAD_POS];

  // Calibration control; the supply logic overrides the test enable bit of a software write in the same cycle.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      calibration_control <= CAL_RESET;
    end else begin
      if (reg_wr && reg_addr == CAL_CTRL_ADDR) begin
        calibration_control <= reg_wdata;
      end
      if (sg_rise || !sg_ok) begin
        calibration_control[FT_POS] <= 1'b0;
      end
    end
  end

  // Bits with no defined default come up at zero here, but software must not count on it.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_bits <= CTRL_INIT;
    end else begin
      if (ctrl_wr) begin
        ctrl_bits <= ctrl_wdata;
      end
      if (sg_rise && battery_retained) begin
        ctrl_bits[HALT_POS] <= 1'b1;
        ctrl_bits[TIMER_EN_POS] <= 1'b0;
      end
    end
  end

  // Square wave phase; held high and re-armed whenever the test is off.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wave <= 1'b1;
      wave_cnt <= '0;
    end else if (sg_ok && freq_test_enable) begin
      if (wave_cnt == WAVE_LAST) begin
        wave_cnt <= '0;
        wave <= !wave;
      end else begin
        wave_cnt <= wave_cnt + 1'b1;
      end
    end else begin
      wave <= 1'b1;
      wave_cnt <= '0;
    end
  end

  // The pin is open drain: it is pulled low for reset and for the low half of the wave.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      test_or_reset_pin_oe <= 1'b1;
      test_or_reset_pin_out <= 1'b0;
    end else begin
      test_or_reset_pin_out <= 1'b0;
      test_or_reset_pin_oe <= !sg_ok || (freq_test_enable && !wave);
    end
  end

  // Factory trim copy. The wait stands in for the slow transfer the host must sit out.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trim_state <= RPDR_TRIM_USER;
      copy_cnt <= '0;
      trim_copy_busy <= 1'b0;
    end else begin
      case (trim_state)
        RPDR_TRIM_USER: begin
          copy_cnt <= '0;
          if (trim_load) begin
            trim_state <= RPDR_TRIM_COPY;
            trim_copy_busy <= 1'b1;
          end
        end
        RPDR_TRIM_COPY: begin
          if (!trim_load) begin
            trim_state <= RPDR_TRIM_USER;
            trim_copy_busy <= 1'b0;
          end else if (copy_cnt == COPY_LAST) begin
            trim_state <= RPDR_TRIM_LOCKED;
            trim_copy_busy <= 1'b0;
          end else begin
            copy_cnt <= copy_cnt + 1'b1;
          end
        end
        RPDR_TRIM_LOCKED: begin
          if (!trim_load) begin
            trim_state <= RPDR_TRIM_USER;
          end
        end
        default: begin
          trim_state <= RPDR_TRIM_USER;
          trim_copy_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      analog_trim <= TRIM_RESET;
    end else if (trim_state == RPDR_TRIM_COPY && trim_load && copy_cnt == COPY_LAST) begin
      analog_trim <= FACTORY_TRIM;
    end else if (reg_wr && reg_addr == TRIM_ADDR && !trim_load &&
                 trim_state == RPDR_TRIM_USER) begin
      analog_trim <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= RDATA_NONE;
    end else if (reg_rd) begin
      reg_rdata <= read_mux(reg_addr, calibration_control, analog_trim);
    end
  end

  property p_wave_toggles;
    @(posedge clk) disable iff (!rst_sync_n)
    (sg_ok && freq_test_enable && wave_cnt == WAVE_LAST) |=> (wave != $past(wave));
  endproperty
  a_wave_toggles: assert property (p_wave_toggles)
    else $error("test wave did not toggle at end of half period");

  property p_wave_low_drives;
    @(posedge clk) disable iff (!rst_sync_n)
    (sg_ok && freq_test_enable && !wave) |=> test_or_reset_pin_oe;
  endproperty
  a_wave_low_drives: assert property (p_wave_low_drives)
    else $error("pin not pulled low in low half of test wave");

  property p_idle_high;
    @(posedge clk) disable iff (!rst_sync_n)
    (sg_ok && !freq_test_enable) |=> !test_or_reset_pin_oe;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("pin pulled low with test off and supply good");

  property p_fail_resets;
    @(posedge clk) disable iff (!rst_sync_n)
    (sg_fall && freq_test_enable) |=> (!freq_test_enable && test_or_reset_pin_oe);
  endproperty
  a_fail_resets: assert property (p_fail_resets)
    else $error("supply failure did not clear test enable and assert reset");

  // Checked for as long as supply stays low, so a short dip does not trip it falsely.
  property p_fail_holds;
    @(posedge clk) disable iff (!rst_sync_n)
    !sg_ok |=> (!freq_test_enable && test_or_reset_pin_oe);
  endproperty
  a_fail_holds: assert property (p_fail_holds)
    else $error("test enable set or reset released while supply low");

  property p_powerup_ft_clear;
    @(posedge clk) disable iff (!rst_sync_n)
    sg_rise |=> !freq_test_enable;
  endproperty
  a_powerup_ft_clear: assert property (p_powerup_ft_clear)
    else $error("test enable not cleared at power-up");

  property p_init_defaults;
    @(posedge clk) disable iff (!rst_sync_n)
    $rose(rst_sync_n) |-> (ctrl_bits == CTRL_INIT);
  endproperty
  a_init_defaults: assert property (p_init_defaults)
    else $error("control bits not at initial defaults after reset");

  property p_subsequent_powerup;
    @(posedge clk) disable iff (!rst_sync_n)
    (sg_rise && battery_retained) |=>
      (ctrl_bits[HALT_POS] && !ctrl_bits[TIMER_EN_POS] &&
       ctrl_bits[RS_LOW_POS] == $past(ctrl_wr ? ctrl_wdata[RS_LOW_POS] : ctrl_bits[RS_LOW_POS]));
  endproperty
  a_subsequent_powerup: assert property (p_subsequent_powerup)
    else $error("battery-backed power-up defaults wrong");

  property p_copy_loads;
    @(posedge clk) disable iff (!rst_sync_n)
    (trim_state == RPDR_TRIM_COPY && trim_load && copy_cnt == COPY_LAST) |=>
      (analog_trim == FACTORY_TRIM && trim_state == RPDR_TRIM_LOCKED && !trim_copy_busy);
  endproperty
  a_copy_loads: assert property (p_copy_loads)
    else $error("factory trim not loaded at end of copy");

  property p_copy_busy;
    @(posedge clk) disable iff (!rst_sync_n)
    (trim_state == RPDR_TRIM_COPY) |-> trim_copy_busy;
  endproperty
  a_copy_busy: assert property (p_copy_busy)
    else $error("copy in progress without busy flag");

  property p_locked_readonly;
    @(posedge clk) disable iff (!rst_sync_n)
    (trim_state == RPDR_TRIM_LOCKED && reg_wr && reg_addr == TRIM_ADDR) |=> $stable(analog_trim);
  endproperty
  a_locked_readonly: assert property (p_locked_readonly)
    else $error("locked analog trim changed on write");

  property p_user_write;
    @(posedge clk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == TRIM_ADDR && !trim_load && trim_state == RPDR_TRIM_USER) |=>
      (analog_trim == $past(reg_wdata));
  endproperty
  a_user_write: assert property (p_user_write)
    else $error("analog trim write not stored");

  property p_sg_sync;
    @(posedge clk) disable iff (!rst_sync_n)
    ($past(rst_sync_n, 2)) |-> (sg_ok == $past(supply_good, 2));
  endproperty
  a_sg_sync: assert property (p_sg_sync)
    else $error("supply good not delayed by two synchroniser stages");

endmodule

// ---- verilog/rpdr_pkg.sv ----
// Constants shared by the power-up, reset pin and trim logic of the clock block.
// Assumes a 40 MHz system clock and byte-wide register access.
package rpdr_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TEST_FREQ_HZ = 512;
  // Half a period of the test wave, rounded down to whole clock cycles.
  localparam int unsigned HALF_CYCLES = CLK_HZ / (2 * TEST_FREQ_HZ);
  localparam int unsigned COPY_TIME_US = 8000;
  localparam int unsigned COPY_CYCLES = (CLK_HZ / 1_000_000) * COPY_TIME_US;

  localparam int unsigned WAVE_CNT_W = 16;
  localparam int unsigned COPY_CNT_W = 19;
  localparam int unsigned CTRL_W = 24;

  localparam logic [7:0] CAL_CTRL_ADDR = 8'h08;
  localparam logic [7:0] TRIM_ADDR = 8'h12;
  localparam int unsigned FT_POS = 6;
  localparam logic [7:0] CAL_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  // Arbitrary stand-in for the factory-programmed trim value.
  localparam logic [7:0] FACTORY_TRIM_DEFAULT = 8'h40;

  // Layout of the loose power-up control bits.
  localparam int unsigned HALT_POS = 0;
  localparam int unsigned OSC_FAIL_POS = 1;
  localparam int unsigned TIMER_EN_POS = 2;
  localparam int unsigned TIMER_PULSE_POS = 3;
  localparam int unsigned TIMER_IRQ_POS = 4;
  localparam int unsigned TCS_LO_POS = 5;
  localparam int unsigned TCS_HI_POS = 6;
  localparam int unsigned RS_LOW_POS = 7;
  localparam int unsigned RS_UP_LSB = 8;
  localparam int unsigned TRIM_LOAD_POS = 11;
  localparam int unsigned A2_IRQ_POS = 12;
  localparam int unsigned A2_EN_POS = 13;
  localparam int unsigned A1_RPT_LSB = 14;
  localparam int unsigned A2_RPT_LSB = 19;
  // Halt, oscillator fail, both timer clock selects and lowest rate select set.
  localparam logic [CTRL_W-1:0] CTRL_INIT = 24'h0000E3;

  typedef enum logic [1:0] {
    RPDR_TRIM_USER,
    RPDR_TRIM_COPY,
    RPDR_TRIM_LOCKED
  } rpdr_trim_state_t;

endpackage

// ---- verilog/rpdr_sync.sv ----
// Two-flop synchroniser with an asynchronous clear to zero.
// Assumes d may change at any time relative to clk.
module rpdr_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

// ---- verif/rpdr_host_model.sv ----
// Host-side model of the processor watching the shared test/reset pin.
// Assumes an open-drain pin with a pull-up, so a released pin reads high.
module rpdr_host_model (
  input wire logic clk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level,
  output logic [15:0] last_run,
  output logic [15:0] edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic [15:0] run;

  // A released pin floats up to the pull-up level, never the last driven value.
  assign pin_level = pin_oe ? pin_out : 1'b1;

  initial begin
    prev = 1'b1;
    run = 16'h0000;
    last_run = 16'h0000;
    edges = 16'h0000;
  end

  // Width of each level run tells the host the test wave half period.
  always @(posedge clk) begin
    if (pin_level !== prev) begin
      last_run <= run;
      run <= 16'h0001;
      edges <= edges + 16'h0001;
      prev <= pin_level;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule

// ---- verif/tb_rpdr_top.sv ----
// Self-checking bench for the power-up, test/reset pin and trim copy block.
// Assumes short counts: a 4-cycle half wave and an 8-cycle trim copy.
module tb_rpdr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rpdr_pkg::*;
  localparam int HALF = 4;
  localparam int COPY = 8;
  logic clk, rst_n, supply_good, battery_retained, reg_wr, reg_rd, ctrl_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, calibration_control, analog_trim, rd_val;
  logic [CTRL_W-1:0] ctrl_wdata, ctrl_bits;
  logic trim_copy_busy, pin_out, pin_oe, pin_level;
  logic [15:0] last_run, edges;
  int err_total, n_checks, n;

  rpdr_top #(.HALF_PERIOD_CYCLES(HALF), .COPY_DELAY_CYCLES(COPY)) u_dut (
    .clk(clk), .rst_n(rst_n), .supply_good(supply_good),
    .battery_retained(battery_retained), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_bits(ctrl_bits),
    .calibration_control(calibration_control), .analog_trim(analog_trim),
    .trim_copy_busy(trim_copy_busy), .test_or_reset_pin_in(pin_level),
    .test_or_reset_pin_out(pin_out), .test_or_reset_pin_oe(pin_oe));

  rpdr_host_model u_host (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level), .last_run(last_run), .edges(edges));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic cwr(input logic [CTRL_W-1:0] w);
    @(negedge clk);
    ctrl_wdata = w;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(20000 * 25);
    err_total++;
    wrap_up();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    rst_n = 1'b0;
    supply_good = 1'b1;
    battery_retained = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_wdata = 24'h000000;
    wait_cyc(10);
    rst_n = 1'b1;
    wait_cyc(8);
    chk(ctrl_bits, 24'h0000E3);
    chk(calibration_control[FT_POS], 1'b0);
    chk(pin_oe, 1'b0);
    wr(TRIM_ADDR, 8'h5A);
    rd(TRIM_ADDR, rd_val);
    chk(rd_val, 8'h5A);
    wr(8'h33, 8'hFF);
    rd(8'h33, rd_val);
    chk(rd_val, RDATA_NONE);
    wr(CAL_CTRL_ADDR, 8'h40);
    chk(calibration_control, 8'h40);
    wait_cyc(6 * HALF);
    chk(last_run, 16'(HALF));
    chk(edges >= 16'h0004, 1'b1);
    cwr(24'h15A3F4);
    chk(ctrl_bits, 24'h15A3F4);
    // Supply fails with the test wave running, then returns on battery backup.
    supply_good = 1'b0;
    battery_retained = 1'b1;
    wait_cyc(5);
    chk(calibration_control[FT_POS], 1'b0);
    chk({pin_oe, pin_level}, 2'b10);
    chk(pin_out, 1'b0);
    supply_good = 1'b1;
    // This test enable write lands on the power-up edge and must lose to it.
    wait_cyc(1);
    wr(CAL_CTRL_ADDR, 8'h40);
    wait_cyc(2);
    chk(ctrl_bits, 24'h15A3F1);
    chk(calibration_control[FT_POS], 1'b0);
    chk(pin_oe, 1'b0);
    cwr(24'h15ABF1);
    n = 0;
    while (trim_copy_busy !== 1'b1 && n < 20) begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    // The host holds off trusting analog trim until the copy is done.
    while (trim_copy_busy === 1'b1 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    chk(n, COPY);
    chk(analog_trim, FACTORY_TRIM_DEFAULT);
    wr(TRIM_ADDR, 8'h11);
    rd(TRIM_ADDR, rd_val);
    chk(rd_val, FACTORY_TRIM_DEFAULT);
    cwr(24'h15A3F1);
    wait_cyc(3);
    wr(TRIM_ADDR, 8'h22);
    rd(TRIM_ADDR, rd_val);
    chk(rd_val, 8'h22);
    wrap_up();
  end
endmodule
